// File: src/lpc_board_regs.sv
`timescale 1ns/10ps
`include "board_ctl_defines.svh"
module lpc_board_regs
   import board_ctl_pkg::*;
#(
   parameter int TICK_CYCLES = `TICK_CYCLES,
   parameter logic [7:0] REV_BCD = `LOGIC_REV_VALUE
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_lframe_n,
   input wire logic [3:0] i_lad,
   output logic [3:0] o_lad,
   output logic o_lad_oe,
   input wire logic [4:0] i_geo_slot_bits,
   output logic [7:0] o_post_code_leds,
   output logic o_board_rst,
   output logic o_wdt_enabled
);
   logic [3:0] lad_s;
   logic lframe_n_s;
   logic [4:0] geo_s;
   lpc_state_t state_q;
   logic is_write_q;
   logic [15:0] addr_q;
   logic [2:0] nib_q;
   logic [7:0] wdata_q;
   logic [7:0] rdata_q;
   logic [7:0] post_code_q;
   logic claim;
   logic wr_done;
   logic rd_done;
   logic wdt_load;
   logic wdt_dis;
   logic wdt_en;
   logic wdt_rst;
   logic [7:0] rd_mux;
   logic [9:0] pins_s;
   logic post_wr;
   logic [7:0] led_d;

   sync2 #(.WIDTH(10)) u_sync (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_async({i_lframe_n, i_lad, i_geo_slot_bits}),
      .o_sync(pins_s)
   );
   assign lframe_n_s = pins_s[9];
   assign lad_s = pins_s[8:5];
   assign geo_s = pins_s[4:0];

   // address claim
   always_comb begin
      claim = 1'b0;
      if (is_write_q) begin
         claim = (addr_q == `ADDR_POST_CODE) || (addr_q == `ADDR_WDT_ENABLE);
      end else begin
         claim = (addr_q == `ADDR_POST_CODE) || (addr_q == `ADDR_WDT_DISABLE) ||
            (addr_q == `ADDR_LOGIC_REV) || (addr_q == `ADDR_SLOT_ADDR);
      end
   end

   // read data select
   always_comb begin
      case (addr_q)
         `ADDR_POST_CODE: rd_mux = post_code_q;
         `ADDR_LOGIC_REV: rd_mux = REV_BCD;
         `ADDR_SLOT_ADDR: rd_mux = {`SLOT_RSVD_ONES, geo_s};
         default: rd_mux = 8'h00;
      endcase
   end

   // cycle framing
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q <= ST_IDLE;
         is_write_q <= 1'b0;
         addr_q <= 16'h0;
         nib_q <= 3'h0;
         wdata_q <= 8'h00;
         rdata_q <= 8'h00;
      end else if (i_ce) begin
         if (!lframe_n_s) begin
            state_q <= (lad_s == `LPC_START) ? ST_CYC : ST_IDLE;
         end else begin
            case (state_q)
               ST_IDLE: state_q <= ST_IDLE;
               ST_CYC: begin
                  nib_q <= 3'h0;
                  if (lad_s == `LPC_CT_IO_WR || lad_s == `LPC_CT_IO_RD) begin
                     is_write_q <= (lad_s == `LPC_CT_IO_WR);
                     state_q <= ST_ADDR;
                  end else begin
                     state_q <= ST_SKIP;
                  end
               end
               ST_ADDR: begin
                  addr_q <= {addr_q[11:0], lad_s};
                  nib_q <= nib_q + 3'h1;
                  if (nib_q == 3'h3) begin
                     nib_q <= 3'h0;
                     state_q <= is_write_q ? ST_WDATA : ST_TAR1;
                  end
               end
               ST_WDATA: begin
                  wdata_q <= {lad_s, wdata_q[7:4]};
                  nib_q <= nib_q + 3'h1;
                  if (nib_q == 3'h1) begin
                     state_q <= claim ? ST_TAR1 : ST_SKIP;
                  end
               end
               ST_TAR1: begin
                  state_q <= claim ? ST_TAR2 : ST_SKIP;
               end
               ST_TAR2: begin
                  rdata_q <= rd_mux;
                  nib_q <= 3'h0;
                  state_q <= ST_SYNC;
               end
               ST_SYNC: state_q <= is_write_q ? ST_TAR3 : ST_RDATA;
               ST_RDATA: begin
                  nib_q <= nib_q + 3'h1;
                  if (nib_q == 3'h1) begin
                     state_q <= ST_TAR3;
                  end
               end
               ST_TAR3: state_q <= ST_TAR4;
               ST_TAR4: state_q <= ST_IDLE;
               ST_SKIP: state_q <= ST_SKIP;
               default: state_q <= ST_IDLE;
            endcase
         end
      end
   end

   assign wr_done = i_ce && lframe_n_s && state_q == ST_SYNC && is_write_q;
   assign rd_done = i_ce && lframe_n_s && state_q == ST_SYNC && !is_write_q;
   assign wdt_load = wr_done && addr_q == `ADDR_WDT_ENABLE;
   assign wdt_dis = rd_done && addr_q == `ADDR_WDT_DISABLE;
   assign post_wr = wr_done && addr_q == `ADDR_POST_CODE;

   // lad drive
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_lad <= 4'h0;
         o_lad_oe <= 1'b0;
      end else if (i_ce) begin
         o_lad_oe <= 1'b0;
         o_lad <= 4'h0;
         if (lframe_n_s) begin
            case (state_q)
               ST_TAR2: begin
                  o_lad_oe <= 1'b1;
                  o_lad <= `LPC_SYNC_READY;
               end
               ST_SYNC: begin
                  if (!is_write_q) begin
                     o_lad_oe <= 1'b1;
                     o_lad <= rdata_q[3:0];
                  end else begin
                     o_lad_oe <= 1'b1;
                     o_lad <= `LPC_TAR;
                  end
               end
               ST_RDATA: begin
                  o_lad_oe <= 1'b1;
                  o_lad <= (nib_q == 3'h0) ? rdata_q[7:4] : `LPC_TAR;
               end
               default: o_lad_oe <= 1'b0;
            endcase
         end
      end
   end

   // post code store
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         post_code_q <= `POST_CODE_RESET;
      end else if (i_ce) begin
         if (post_wr) begin
            post_code_q <= wdata_q;
         end
      end
   end

   // next value per led segment, bit 7 on the top segment
   for (genvar b = 0; b < 8; b++) begin : g_led
      assign led_d[b] = post_wr ? wdata_q[b] : o_post_code_leds[b];
   end

   // led drive
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_post_code_leds <= `POST_CODE_RESET;
      end else if (i_ce) begin
         o_post_code_leds <= led_d;
      end
   end

   watchdog_sec #(.TICK_CYCLES(TICK_CYCLES)) u_wdt (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_load(wdt_load),
      .i_load_val(wdata_q),
      .i_disable(wdt_dis),
      .o_enabled(wdt_en),
      .o_board_rst(wdt_rst)
   );

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_board_rst <= 1'b0;
         o_wdt_enabled <= 1'b0;
      end else if (i_ce) begin
         o_board_rst <= wdt_rst;
         o_wdt_enabled <= wdt_en;
      end
   end

   AST_LED_FOLLOWS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_post_code_leds == post_code_q)
      else $error("leds differ from debug code");
   AST_SLOT_TOP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && lframe_n_s && state_q == ST_TAR2 && addr_q == `ADDR_SLOT_ADDR && !is_write_q)
      |=> rdata_q[7:5] == 3'h7 && rdata_q[4:0] == $past(geo_s))
      else $error("slot register wrong");
   AST_NO_443_READ: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state_q == ST_TAR1 && !is_write_q && addr_q == `ADDR_WDT_ENABLE && i_ce && lframe_n_s)
      |=> state_q == ST_SKIP)
      else $error("read of 443h claimed");
   AST_447_WRITE_IGNORED: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state_q == ST_WDATA && nib_q == 3'h1 && is_write_q && addr_q == `ADDR_SLOT_ADDR
      && i_ce && lframe_n_s) |=> state_q == ST_SKIP)
      else $error("write of 447h claimed");
   AST_POST_WRITE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (wr_done && addr_q == `ADDR_POST_CODE) |=> post_code_q == $past(wdata_q))
      else $error("debug code not captured");
   AST_REV_READ: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && lframe_n_s && state_q == ST_TAR2 && addr_q == `ADDR_LOGIC_REV)
      |=> rdata_q == REV_BCD)
      else $error("revision read wrong");
   AST_DEBUG_READ: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && lframe_n_s && state_q == ST_TAR2 && addr_q == `ADDR_POST_CODE)
      |=> rdata_q == $past(post_code_q))
      else $error("debug read wrong");
   AST_REFRESH: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (wdt_load && wdata_q != 8'h00) |=> ##1 o_wdt_enabled)
      else $error("refresh did not keep watchdog on");
   // bus cycle checks
   AST_STATE_ONEHOT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $onehot(state_q))
      else $error("framing state not one-hot");
   AST_FRAME_START: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && !lframe_n_s && lad_s == `LPC_START) |=> state_q == ST_CYC)
      else $error("start nibble not taken");
   AST_FRAME_ABORT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && !lframe_n_s && lad_s != `LPC_START) |=> state_q == ST_IDLE)
      else $error("foreign frame not dropped");
   AST_UNCLAIMED_SKIP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && lframe_n_s && state_q == ST_TAR1 && !claim)
      |=> state_q == ST_SKIP && !o_lad_oe)
      else $error("unclaimed cycle answered");
   AST_READ_444: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && lframe_n_s && state_q == ST_TAR1 && !is_write_q && addr_q == `ADDR_WDT_DISABLE)
      |=> state_q == ST_TAR2)
      else $error("read of 444h not claimed");
   AST_CLAIM_WRITE_80: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && lframe_n_s && state_q == ST_WDATA && nib_q == 3'h1 && is_write_q
      && addr_q == `ADDR_POST_CODE) |=> state_q == ST_TAR1)
      else $error("write of 80h not claimed");
   AST_SYNC_DRIVE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && lframe_n_s && state_q == ST_TAR2)
      |=> o_lad_oe && o_lad == `LPC_SYNC_READY)
      else $error("sync nibble missing");
   AST_WRITE_TAR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && lframe_n_s && state_q == ST_SYNC && is_write_q)
      |=> o_lad_oe && o_lad == `LPC_TAR)
      else $error("write turnaround missing");
   AST_READ_LOW: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && lframe_n_s && state_q == ST_SYNC && !is_write_q)
      |=> o_lad_oe && o_lad == $past(rdata_q[3:0]))
      else $error("read low nibble wrong");
   AST_READ_HIGH: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && lframe_n_s && state_q == ST_RDATA && nib_q == 3'h0)
      |=> o_lad_oe && o_lad == $past(rdata_q[7:4]))
      else $error("read high nibble wrong");
   AST_READ_END: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && lframe_n_s && state_q == ST_RDATA && nib_q == 3'h1)
      |=> o_lad_oe && o_lad == `LPC_TAR && state_q == ST_TAR3)
      else $error("read turnaround missing");
   AST_IDLE_SILENT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state_q == ST_IDLE) |-> !o_lad_oe)
      else $error("bus driven while idle");
   AST_SKIP_SILENT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state_q == ST_SKIP) |-> !o_lad_oe)
      else $error("bus driven on skipped cycle");

   // register and watchdog checks
   AST_POST_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && !post_wr) |=> $stable(post_code_q))
      else $error("debug code changed without write");
   AST_LED_LOAD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      post_wr |=> o_post_code_leds == $past(wdata_q))
      else $error("leds not loaded by write");
   AST_CE_FREEZE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (!i_ce) |=> $stable(state_q) && $stable(post_code_q) && $stable(o_lad_oe)
      && $stable(o_board_rst) && $stable(o_wdt_enabled))
      else $error("state moved while clock enable low");
   AST_DIS_OUTPUT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (wdt_dis ##1 i_ce) |=> !o_wdt_enabled)
      else $error("enable output stayed on after disable");
   COV_CE_HOLD: cover property (@(posedge i_clk) !i_ce && o_wdt_enabled);
   COV_POST_WR: cover property (@(posedge i_clk) wr_done && addr_q == `ADDR_POST_CODE);
   COV_WDT_DIS: cover property (@(posedge i_clk) wdt_dis);
   COV_SLOT_RD: cover property (@(posedge i_clk) rd_done && addr_q == `ADDR_SLOT_ADDR);
endmodule // lpc_board_regs

// File: src/board_ctl_defines.svh
// Behaviour
// - The block claims host I/O cycles at 80h, 443h, 444h, 445h and 447h; 443h takes writes only and the other four answer reads.
// - The block holds the latest 8-bit debug code, any value 00h to FFh, and returns it on a read of 80h.
// - Each debug code bit drives one LED segment directly, bit 7 to the top LED and bit 0 to the bottom.
// - A nonzero write to 443h enables the watchdog and loads the written value as its timeout.
// - The timeout equals the loaded value in whole seconds, one second per count, 1 to 255 seconds.
// - Any read of 444h disables the watchdog so no timeout happens until the next enabling write.
// - The revision register returns two BCD digits, units in bits 7 to 4 and tenths in bits 3 to 0.
// - Bits 7 to 5 of the slot address register always read as ones.
// - Bits 4 to 0 of the slot address register follow the five geographic address inputs, bit 4 on top.
// - The slot address register at 447h is read-only and host writes to it do nothing.
// - Each nonzero host write to 443h reloads the watchdog count and restarts timing from the written value.
`ifndef BOARD_CTL_DEFINES_SVH
`define BOARD_CTL_DEFINES_SVH
`define ADDR_POST_CODE 16'h0080
`define ADDR_WDT_ENABLE 16'h0443
`define ADDR_WDT_DISABLE 16'h0444
`define ADDR_LOGIC_REV 16'h0445
`define ADDR_SLOT_ADDR 16'h0447
`define SLOT_RSVD_ONES 3'h7
`define POST_CODE_RESET 8'h00
`define LOGIC_REV_VALUE 8'h10
`define CLK_HZ 20000000
`define TICK_SECONDS 1
`define TICK_CYCLES (`CLK_HZ * `TICK_SECONDS)
`define RESET_PULSE_CYCLES 4
`define LPC_START 4'h0
`define LPC_CT_IO_RD 4'h0
`define LPC_CT_IO_WR 4'h2
`define LPC_SYNC_READY 4'h0
`define LPC_TAR 4'hf
`endif

// File: src/board_ctl_pkg.sv
package board_ctl_pkg;
   typedef enum logic [10:0] {
      ST_IDLE = 11'h001,
      ST_CYC = 11'h002,
      ST_ADDR = 11'h004,
      ST_WDATA = 11'h008,
      ST_TAR1 = 11'h010,
      ST_TAR2 = 11'h020,
      ST_SYNC = 11'h040,
      ST_RDATA = 11'h080,
      ST_TAR3 = 11'h100,
      ST_TAR4 = 11'h200,
      ST_SKIP = 11'h400
   } lpc_state_t;
endpackage

// File: src/sync2.sv
`timescale 1ns/10ps
module sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         meta_q <= '0;
         o_sync <= '0;
      end else if (i_ce) begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule // sync2

// File: src/watchdog_sec.sv
`timescale 1ns/10ps
`include "board_ctl_defines.svh"
module watchdog_sec #(
   parameter int TICK_CYCLES = `TICK_CYCLES,
   parameter int PULSE_CYCLES = `RESET_PULSE_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_load,
   input wire logic [7:0] i_load_val,
   input wire logic i_disable,
   output logic o_enabled,
   output logic o_board_rst
);
   logic [7:0] secs_q;
   logic [31:0] tick_q;
   logic [7:0] pulse_q;
   logic tick_end;
   logic expire;
   assign tick_end = (tick_q == 32'(TICK_CYCLES - 1));
   // a zero write does not reload, so it must not swallow the expiry
   assign expire = o_enabled && tick_end && (secs_q == 8'h01) &&
      !(i_load && i_load_val != 8'h00) && !i_disable;
   // enable, reload and disable
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_enabled <= 1'b0;
         secs_q <= 8'h00;
         tick_q <= 32'h0;
      end else if (i_ce) begin
         if (i_load && i_load_val != 8'h00) begin
            o_enabled <= 1'b1;
            secs_q <= i_load_val;
            tick_q <= 32'h0;
         end else if (i_disable) begin
            o_enabled <= 1'b0;
         end else if (o_enabled) begin
            if (tick_end) begin
               tick_q <= 32'h0;
               secs_q <= secs_q - 8'h01;
               if (secs_q == 8'h01) begin
                  o_enabled <= 1'b0;
               end
            end else begin
               tick_q <= tick_q + 32'h1;
            end
         end
      end
   end
   // reset pulse
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pulse_q <= 8'h00;
         o_board_rst <= 1'b0;
      end else if (i_ce) begin
         if (expire) begin
            pulse_q <= 8'(PULSE_CYCLES);
            o_board_rst <= 1'b1;
         end else if (pulse_q > 8'h01) begin
            pulse_q <= pulse_q - 8'h01;
         end else begin
            pulse_q <= 8'h00;
            o_board_rst <= 1'b0;
         end
      end
   end
   AST_EXPIRE_PULSE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && expire) |=> o_board_rst && !o_enabled)
      else $error("expiry did not raise reset");
   AST_LOAD_ENABLES: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && i_load && i_load_val != 8'h00) |=> o_enabled && secs_q == $past(i_load_val))
      else $error("nonzero load did not enable");
   AST_DISABLE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && i_disable && !i_load) |=> !o_enabled)
      else $error("disable read ignored");
   AST_NO_RST_IDLE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (!o_enabled && !o_board_rst && i_ce) |=> !o_board_rst)
      else $error("reset without armed watchdog");
   COV_EXPIRE: cover property (@(posedge i_clk) disable iff (i_sys_rst) o_board_rst);
endmodule // watchdog_sec

// File: sim/lpc_host_model.sv
`timescale 1ns/10ps
module lpc_host_model (
   input wire logic i_clk,
   input wire logic [3:0] i_dev_lad,
   input wire logic i_dev_oe,
   output logic o_lframe_n,
   output logic [3:0] o_lad_bus
);
   logic host_oe;
   logic [3:0] host_lad;
   // pull-up level when nobody drives
   assign o_lad_bus = i_dev_oe ? i_dev_lad : (host_oe ? host_lad : 4'hf);
   initial begin
      o_lframe_n = 1'b1;
      host_oe = 1'b0;
      host_lad = 4'hf;
   end
   task automatic put(input logic [3:0] nib, input logic fr);
      @(posedge i_clk);
      #1;
      host_oe = 1'b1;
      host_lad = nib;
      o_lframe_n = fr;
   endtask
   // one i/o cycle; claimed when sync, any read data and final nibble all seen
   task automatic io_cycle(input logic wr, input logic [15:0] addr, input logic [7:0] wd,
                           output logic [7:0] rd, output logic claimed);
      logic [3:0] q[$];
      int n;
      int want;
      q = {};
      want = wr ? 2 : 4;
      put(4'h0, 1'b0);
      put(wr ? 4'h2 : 4'h0, 1'b1);
      for (n = 3; n >= 0; n--) put(addr[n*4+:4], 1'b1);
      if (wr) begin
         put(wd[3:0], 1'b1);
         put(wd[7:4], 1'b1);
      end
      put(4'hf, 1'b1);
      put(4'hf, 1'b1);
      @(posedge i_clk);
      #1;
      host_oe = 1'b0;
      for (n = 0; n < 12 && q.size() < want; n++) begin
         @(posedge i_clk);
         #1;
         if (i_dev_oe === 1'b1) q.push_back(i_dev_lad);
      end
      claimed = (q.size() == want) && (q[0] === 4'h0) && (q[want-1] === 4'hf);
      rd = (!wr && claimed) ? {q[2], q[1]} : 8'h00;
      repeat (2) @(posedge i_clk);
      #1;
   endtask
endmodule // lpc_host_model

// File: sim/testbench.sv
`timescale 1ns/10ps
module testbench;
   import board_ctl_pkg::*;
   localparam int TICK = 10;
   localparam logic [7:0] REV = 8'h14;
   logic i_clk;
   logic i_sys_rst;
   logic [4:0] geo;
   logic lframe_n;
   logic [3:0] lad_bus;
   logic [3:0] dev_lad;
   logic dev_oe;
   logic [7:0] leds;
   logic brst;
   logic wen;
   logic [7:0] rd;
   logic ok;
   logic ce;
   logic [31:0] rng;
   int err_total;
   int n_compared;
   int cyc;
   int mdl_post;
   int t;
   lpc_board_regs #(.TICK_CYCLES(TICK), .REV_BCD(REV)) i_dut (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_ce(ce),
      .i_lframe_n(lframe_n),
      .i_lad(lad_bus),
      .o_lad(dev_lad),
      .o_lad_oe(dev_oe),
      .i_geo_slot_bits(geo),
      .o_post_code_leds(leds),
      .o_board_rst(brst),
      .o_wdt_enabled(wen)
   );
   lpc_host_model i_host (
      .i_clk(i_clk),
      .i_dev_lad(dev_lad),
      .i_dev_oe(dev_oe),
      .o_lframe_n(lframe_n),
      .o_lad_bus(lad_bus)
   );
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] wd);
      i_host.io_cycle(wr, a, wd, rd, ok);
   endtask
   task automatic wait_rst(input int lim);
      t = 0;
      while (brst !== 1'b1 && t < lim) begin
         @(posedge i_clk);
         #1;
         t++;
      end
   endtask
   // arm with n, expect a reset after n ticks, then check the pulse width and that it is off
   task automatic wdt(input int n);
      acc(1'b1, 16'h0443, n[7:0]);
      cmp("wdt_armed", 1, wen);
      wait_rst(n * TICK + 40);
      cmp("wdt_delay_ok", 1, (t >= (n - 1) * TICK) && (t <= n * TICK + 8));
      t = 0;
      while (brst === 1'b1 && t < 20) begin
         @(posedge i_clk);
         #1;
         t++;
      end
      cmp("rst_width", 4, t);
      cmp("wdt_off", 0, wen);
   endtask
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         complete_run();
      end
   end
   initial begin
      err_total = 0;
      n_compared = 0;
      cyc = 0;
      rng = 32'hd290;
      ce = 1'b1;
      geo = 5'h00;
      i_sys_rst = 1'b1;
      repeat (3) @(posedge i_clk);
      #1;
      i_sys_rst = 1'b0;
      cmp("wdt_rst", 0, wen);
      for (int k = 0; k < 6; k++) begin
         rng = xs(rng);
         mdl_post = (k == 0) ? 0 : (k == 1) ? 255 : int'(rng[7:0]);
         acc(1'b1, 16'h0080, mdl_post[7:0]);
         cmp("wr80_claim", 1, ok);
         cmp("leds", mdl_post, leds);
         acc(1'b0, 16'h0080, 8'h00);
         cmp("rd80", mdl_post, rd);
      end
      acc(1'b0, 16'h0445, 8'h00);
      cmp("rev", REV, rd);
      for (int k = 0; k < 4; k++) begin
         rng = xs(rng);
         geo = (k == 0) ? 5'h10 : (k == 1) ? 5'h01 : rng[4:0];
         repeat (4) @(posedge i_clk);
         #1;
         acc(1'b1, 16'h0447, 8'h00);
         cmp("wr447_ignored", 0, ok);
         acc(1'b0, 16'h0447, 8'h00);
         cmp("slot", {3'h7, geo}, rd);
      end
      acc(1'b0, 16'h0443, 8'h00);
      cmp("rd443_claim", 0, ok);
      acc(1'b0, 16'h0446, 8'h00);
      cmp("rd446_claim", 0, ok);
      acc(1'b1, 16'h0445, 8'h33);
      cmp("wr445_claim", 0, ok);
      acc(1'b0, 16'h0444, 8'h00);
      cmp("rd444_claim", 1, ok);
      acc(1'b1, 16'h0443, 8'h00);
      cmp("wdt_zero_write", 0, wen);
      wdt(1);
      wdt(3);
      wdt(255);
      acc(1'b1, 16'h0443, 8'h05);
      acc(1'b1, 16'h0443, 8'h00);
      cmp("wdt_zero_keeps", 1, wen);
      repeat (10) @(posedge i_clk);
      #1;
      wdt(5);
      acc(1'b1, 16'h0443, 8'h05);
      acc(1'b0, 16'h0444, 8'h00);
      cmp("wdt_disabled", 0, wen);
      wait_rst(80);
      cmp("no_rst_after_disable", 0, brst);
      // clock enable low freezes the armed countdown
      acc(1'b1, 16'h0443, 8'h02);
      ce = 1'b0;
      repeat (50) @(posedge i_clk);
      #1;
      cmp("ce_hold_rst", 0, brst);
      cmp("ce_hold_en", 1, wen);
      ce = 1'b1;
      wait_rst(3 * TICK);
      // two clocks ran between load and freeze, plus the output stage
      cmp("ce_resume_delay", 2 * TICK - 1, t);
      repeat (8) @(posedge i_clk);
      #1;
      cmp("ce_resume_off", 0, wen);
      // reset in mid-run clears debug code and watchdog
      acc(1'b1, 16'h0080, 8'ha5);
      cmp("leds_pre_rst", 8'ha5, leds);
      acc(1'b1, 16'h0443, 8'h03);
      i_sys_rst = 1'b1;
      @(posedge i_clk);
      #1;
      i_sys_rst = 1'b0;
      mdl_post = 0;
      cmp("rst_leds", mdl_post, leds);
      cmp("rst_wdt_off", 0, wen);
      wait_rst(4 * TICK);
      cmp("rst_no_expiry", 0, brst);
      acc(1'b0, 16'h0080, 8'h00);
      cmp("rst_rd80", mdl_post, rd);
      complete_run();
   end
endmodule // testbench
